// File: testbench/uart_peer_model.sv
`timescale 1ns/1ps
module uart_peer_model (
  // clock
  input wire logic i_core_clk,
  // line side of the block
  input wire logic i_tx_pin,
  output uart_ctl_pkg::pin_in_t o_pins
);
  import uart_ctl_pkg::*;
  // remote lines idle high, as the pull-ups would leave them
  pin_in_t lines_q = '1;
  logic last_tx_q = 1'h1;
  assign o_pins = lines_q;
  always @(posedge i_core_clk) begin
    last_tx_q <= i_tx_pin;
  end
  // new line levels land just after a clock edge
  task set_lines(input pin_in_t v);
    @(posedge i_core_clk);
    lines_q <= v;
  endtask : set_lines
endmodule : uart_peer_model

// File: testbench/usb_uart_control_status_tb.sv
`timescale 1ns/1ps
`include "uart_ctl_regs.svh"
module usb_uart_control_status_tb;
  import uart_ctl_pkg::*;
  logic clk = 1'h0, rst_b = 1'h0, hsel = 1'h0, hw = 1'h0;
  logic [1:0] htr = 2'h0;
  logic [31:0] ha = 32'h0, hwd = 32'h0, rd, o_hrdata;
  ahb_req_t ahb;
  pin_in_t pins;
  logic o_hreadyout, o_hresp, o_tx_pin, o_tx_oe, o_rx_line, o_cts, o_dsr;
  logic o_resume_req, o_tx_flush, o_rx_flush, o_tx_char_valid;
  logic o_flow_assert, o_class_mode_ok, s;
  logic [7:0] o_pullup, o_pulldown, txq_b = 8'h0;
  logic [19:0] o_int_status;
  logic [8:0] o_tx_char;
  logic [9:0] o_bulk_max;
  logic tx_line = 1'h1, rts = 1'h0, dtr = 1'h0, int_gen = 1'h0;
  logic txq_v = 1'h0, nine = 1'h0, hs = 1'h1;
  logic bs = 1'h0, ost = 1'h0, rx_v = 1'h0;
  logic o_rxq_valid, o_low_latency, o_driver_active;
  logic [7:0] rx_c = 8'h0, o_rxq_byte;
  logic [3:0] rx_e = 4'h0;
  logic [3:0] err_ev = 4'h0;
  logic [10:0] tx_fill = 11'h0, rx_fill = 11'h0;
  logic [2:0] flow = 3'h0;
  logic [9:0] lim [4] = '{10'h040, 10'h200, 10'h03C, 10'h1FC};
  int bad_count = 0, n_checks = 0;
  assign ahb = {hsel, htr, ha, hw, 3'h2, hwd, o_hreadyout};
  always #12.5 clk = ~clk;
  uart_peer_model u_uart_peer_model (.i_core_clk(clk), .i_tx_pin(o_tx_pin),
    .o_pins(pins));
  usb_uart_control_status u_usb_uart_control_status (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_ahb(ahb), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_pins(pins),
    .o_tx_pin(o_tx_pin), .o_tx_oe(o_tx_oe), .o_pullup(o_pullup),
    .o_pulldown(o_pulldown), .i_tx_line(tx_line), .i_bit_start(bs),
    .i_os_tick(ost), .o_rx_line(o_rx_line), .i_rts(rts), .i_dtr(dtr),
    .o_cts(o_cts), .o_dsr(o_dsr), .i_err_event(err_ev),
    .i_int_gen(int_gen), .o_int_status(o_int_status),
    .o_resume_req(o_resume_req), .i_tx_fill(tx_fill), .i_rx_fill(rx_fill),
    .o_tx_flush(o_tx_flush), .o_rx_flush(o_rx_flush), .i_txq_valid(txq_v),
    .i_txq_byte(txq_b), .i_nine_bit(nine), .o_tx_char(o_tx_char),
    .o_tx_char_valid(o_tx_char_valid), .i_rx_char_valid(rx_v),
    .i_rx_char(rx_c), .i_rx_err(rx_e), .o_rxq_byte(o_rxq_byte),
    .o_rxq_valid(o_rxq_valid),
    .i_high_speed(hs), .i_flow_mode(flow), .o_bulk_max(o_bulk_max),
    .o_low_latency(o_low_latency), .o_flow_assert(o_flow_assert),
    .o_driver_active(o_driver_active),
    .o_class_mode_ok(o_class_mode_ok));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one single word transfer; entered just after a clock edge
  task xfer(input logic w, input logic [7:0] ix, input logic [15:0] d);
    hsel <= 1'h1;
    htr <= 2'h2;
    hw <= w;
    ha <= {22'h0, ix, 2'h0};
    do @(posedge clk); while (o_hreadyout !== 1'h1);
    hsel <= 1'h0;
    htr <= 2'h0;
    hwd <= {16'h0, d};
    do @(posedge clk); while (o_hreadyout !== 1'h1);
    rd = o_hrdata;
  endtask : xfer
  task rdc(input logic [7:0] ix, input logic [31:0] exp);
    xfer(1'h0, ix, 16'h0);
    chk(rd, exp);
  endtask : rdc
  task watch_wake(input pin_in_t v);
    u_uart_peer_model.set_lines(v);
    s = 1'h0;
    repeat (8) begin
      @(posedge clk);
      if (o_resume_req === 1'h1) s = 1'h1;
    end
  endtask : watch_wake
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(`RI_PULLUP, 32'hFF);
    rdc(`RI_WAKE, 32'h4);
    rdc(`RI_THR, 32'h2E0);
    rdc(`RI_TXLVL, 32'h0);
    rdc(`RI_RXLVL, 32'h0);
    rdc(`RI_LOOP, 32'h0);
    rdc(`RI_DRV, 32'h0);
    chk(o_class_mode_ok, 32'h1);
    xfer(1'h1, 8'h70, 16'hFFFF);
    rdc(8'h70, 32'h0);
  endtask : t_reset
  task t_pull;
    xfer(1'h1, `RI_PULLUP, 16'h0F);
    xfer(1'h1, `RI_PULLDN, 16'hFF);
    cyc(2);
    chk(o_pullup, 32'h0F);
    chk(o_pulldown, 32'hF0);
    xfer(1'h1, `RI_DRV, 16'h1);
    cyc(1);
    chk(o_class_mode_ok, 32'h0);
    chk(o_driver_active, 32'h1);
  endtask : t_pull
  task t_loop;
    u_uart_peer_model.set_lines(5'h13);
    rts <= 1'h1;
    dtr <= 1'h1;
    tx_line <= 1'h0;
    xfer(1'h1, `RI_LOOP, 16'h7);
    cyc(4);
    chk(o_tx_oe, 32'h0);
    chk(o_rx_line, 32'h0);
    chk({o_cts, o_dsr}, 32'h3);
    xfer(1'h1, `RI_LOOP, 16'h0);
    cyc(4);
    chk({o_tx_oe, o_rx_line}, 32'h3);
    chk({o_cts, o_dsr}, 32'h0);
    tx_line <= 1'h1;
  endtask : t_loop
  task t_int;
    u_uart_peer_model.set_lines(5'h11);
    err_ev <= 4'h8;
    cyc(1);
    err_ev <= 4'h0;
    for (int i = 0; i < 2; i++) begin
      cyc(3);
      int_gen <= 1'h1;
      cyc(1);
      int_gen <= 1'h0;
      cyc(1);
      chk(o_int_status, i ? 32'h02900 : 32'h8293E);
    end
  endtask : t_int
  task t_lvl;
    tx_fill <= 11'h155;
    rx_fill <= 11'h7FF;
    xfer(1'h1, `RI_TXLVL, 16'h1);
    rdc(`RI_TXLVL, 32'h155);
    rdc(`RI_RXLVL, 32'h400);
  endtask : t_lvl
  task t_flush;
    for (int i = 0; i < 2; i++) begin
      xfer(1'h1, i ? `RI_RXFL : `RI_TXFL, 16'h1);
      #1;
      chk({o_tx_flush, o_rx_flush}, i ? 32'h1 : 32'h2);
      @(posedge clk);
      xfer(1'h1, i ? `RI_RXFL : `RI_TXFL, 16'h0);
      #1;
      chk({o_tx_flush, o_rx_flush}, 32'h0);
      @(posedge clk);
      rdc(i ? `RI_RXFL : `RI_TXFL, 32'h0);
    end
  endtask : t_flush
  task t_bulk;
    for (int i = 0; i < 4; i++) begin
      hs <= i[0];
      xfer(1'h1, `RI_BULK, {14'h0, i[1], i[0]});
      cyc(1);
      chk(o_bulk_max, lim[i]);
      chk(o_low_latency, i[0]);
    end
  endtask : t_bulk
  task t_flow;
    xfer(1'h1, `RI_THR, 16'h100);
    for (int m = 0; m < 4; m++) begin
      flow <= m[2:0];
      rx_fill <= 11'h101;
      cyc(3);
      chk(o_flow_assert, m == 1 || m == 2);
      rx_fill <= 11'h100;
      cyc(3);
      chk(o_flow_assert, 32'h0);
    end
  endtask : t_flow
  task t_wide;
    xfer(1'h1, `RI_TXFMT, 16'h1);
    nine <= 1'h1;
    txq_v <= 1'h1;
    txq_b <= 8'hA5;
    @(posedge clk);
    txq_b <= 8'h03;
    @(posedge clk);
    txq_v <= 1'h0;
    repeat (3) begin
      @(posedge clk);
      if (o_tx_char_valid === 1'h1) break;
    end
    chk({o_tx_char_valid, o_tx_char}, 32'h3A5);
  endtask : t_wide
  task t_wake;
    xfer(1'h1, `RI_WAKE, 16'h8);
    watch_wake(5'h01);
    chk(s, 32'h1);
    watch_wake(5'h00);
    chk(s, 32'h0);
    watch_wake(5'h11);
    xfer(1'h1, `RI_WAKE, 16'h4);
    watch_wake(5'h10);
    chk(s, 32'h1);
  endtask : t_wake
  task t_ir;
    int n;
    for (int w = 0; w < 2; w++) begin
      xfer(1'h1, `RI_IR, w ? 16'h5 : 16'h3);
      cyc(3);
      chk(o_rx_line, w ? 32'h1 : 32'h0);
      tx_line <= 1'h0;
      bs <= 1'h1;
      ost <= 1'h1;
      @(posedge clk);
      bs <= 1'h0;
      n = 0;
      repeat (8) begin
        @(posedge clk);
        if (o_tx_pin === 1'h1) n++;
      end
      ost <= 1'h0;
      tx_line <= 1'h1;
      chk(n, w ? 32'h4 : 32'h3);
    end
  endtask : t_ir
  task t_rx;
    xfer(1'h1, `RI_RXFMT, 16'h1);
    rx_v <= 1'h1;
    rx_c <= 8'h5A;
    rx_e <= 4'h9;
    @(posedge clk);
    rx_v <= 1'h0;
    @(posedge clk);
    chk({o_rxq_valid, o_rxq_byte}, 32'h15A);
    @(posedge clk);
    chk({o_rxq_valid, o_rxq_byte}, 32'h109);
  endtask : t_rx
  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    t_reset;
    t_pull;
    t_loop;
    t_int;
    t_lvl;
    t_flush;
    t_bulk;
    t_flow;
    t_wide;
    t_wake;
    t_ir;
    t_rx;
    give_verdict;
  end
  initial begin
    #50000;
    bad_count++;
    give_verdict;
  end
endmodule : usb_uart_control_status_tb

// File: verilog/uart_ctl_pkg.sv
package uart_ctl_pkg;
  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;
  typedef struct packed {
    logic rx;
    logic cts;
    logic dsr;
    logic cd;
    logic ri;
  } pin_in_t;
  typedef struct packed {
    logic [7:0] pu, pd;
    logic [2:0] lb, ir;
    logic [1:0] wake;
    logic txw, rxw;
    logic [1:0] bulk;
    logic [10:0] thr;
    logic drv;
    logic [3:0] err;
    logic [5:0] chg, prev;
    logic [19:0] iword;
    logic [4:0] s1, s2;
    logic prx, pri, resume, txfl, rxfl, flow;
    logic [10:0] txlvl, rxlvl;
    logic [15:0] rd;
    logic ph_wr;
    logic [7:0] ph_idx;
    logic [7:0] tfirst;
    logic thalf;
    logic [8:0] tch;
    logic tch_v;
    logic [3:0] rhold;
    logic rpend;
    logic [7:0] rxb;
    logic rxb_v;
    logic [2:0] ircnt;
    logic txo, rxo;
  } state_t;
endpackage : uart_ctl_pkg

// File: verilog/uart_ctl_regs.svh
`ifndef UART_CTL_REGS_SVH
`define UART_CTL_REGS_SVH
`define RI_PULLUP 8'h54
`define RI_PULLDN 8'h55
`define RI_LOOP 8'h56
`define RI_IR 8'h57
`define RI_WAKE 8'h5F
`define RI_TXFL 8'h60
`define RI_TXLVL 8'h61
`define RI_TXFMT 8'h62
`define RI_RXFL 8'h63
`define RI_RXLVL 8'h64
`define RI_RXFMT 8'h65
`define RI_BULK 8'h66
`define RI_THR 8'h67
`define RI_DRV 8'h81
`define RST_PULLUP 8'hFF
`define RST_WAKE 2'h1
`define RST_THR 11'h2E0
`define RST_PREV 6'h17
`define IR_W3 3'h3
`define IR_W4 3'h4
`define FC_NONE 3'h0
`define FC_HW 3'h1
`define FC_SW 3'h2
`define BULK_HS 10'h200
`define BULK_FS 10'h040
`define BULK_HS_S 10'h1FC
`define BULK_FS_S 10'h03C
`endif

// File: verilog/usb_uart_control_status.sv
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`include "uart_ctl_regs.svh"
module usb_uart_control_status #(
  parameter logic [10:0] FIFO_BYTES = 11'd1024
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // register bus
  input wire uart_ctl_pkg::ahb_req_t i_ahb,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // pins
  input wire uart_ctl_pkg::pin_in_t i_pins,
  output logic o_tx_pin,
  output logic o_tx_oe,
  output logic [7:0] o_pullup,
  output logic [7:0] o_pulldown,
  // uart core side
  input wire logic i_tx_line,
  input wire logic i_bit_start,
  input wire logic i_os_tick,
  output logic o_rx_line,
  input wire logic i_rts,
  input wire logic i_dtr,
  output logic o_cts,
  output logic o_dsr,
  input wire logic [3:0] i_err_event,
  input wire logic i_int_gen,
  output logic [19:0] o_int_status,
  output logic o_resume_req,
  // queues
  input wire logic [10:0] i_tx_fill,
  input wire logic [10:0] i_rx_fill,
  output logic o_tx_flush,
  output logic o_rx_flush,
  input wire logic i_txq_valid,
  input wire logic [7:0] i_txq_byte,
  input wire logic i_nine_bit,
  output logic [8:0] o_tx_char,
  output logic o_tx_char_valid,
  input wire logic i_rx_char_valid,
  input wire logic [7:0] i_rx_char,
  input wire logic [3:0] i_rx_err,
  output logic [7:0] o_rxq_byte,
  output logic o_rxq_valid,
  // configuration
  input wire logic i_high_speed,
  input wire logic [2:0] i_flow_mode,
  output logic [9:0] o_bulk_max,
  output logic o_low_latency,
  output logic o_flow_assert,
  output logic o_driver_active,
  output logic o_class_mode_ok
);
  import uart_ctl_pkg::*;

  state_t q, d;
  logic [5:0] lvl;
  logic cts_e, dsr_e, acc;
  logic [7:0] aidx;

  //////////////////////////////////////////////////////////////////////
  // modem lines as seen internally
  always_comb begin
    cts_e = q.lb[1] ? i_rts : q.s2[3];
    dsr_e = q.lb[2] ? i_dtr : q.s2[2];
    lvl = {i_rts, cts_e, i_dtr, dsr_e, q.s2[1], q.s2[0]};
    acc = i_ahb.hsel & i_ahb.htrans[1] & i_ahb.hready;
    aidx = i_ahb.haddr[9:2];
  end

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    d.s1 = i_pins;
    d.s2 = q.s1;
    d.txfl = 1'b0;
    d.rxfl = 1'b0;
    d.resume = 1'b0;
    // register writes land in the data phase
    d.ph_wr = acc & i_ahb.hwrite;
    d.ph_idx = aidx;
    if (q.ph_wr) begin
      if (q.ph_idx == `RI_PULLUP) begin
        d.pu = i_ahb.hwdata[7:0];
      end else if (q.ph_idx == `RI_PULLDN) begin
        d.pd = i_ahb.hwdata[7:0];
      end else if (q.ph_idx == `RI_LOOP) begin
        d.lb = i_ahb.hwdata[2:0];
      end else if (q.ph_idx == `RI_IR) begin
        d.ir = i_ahb.hwdata[2:0];
      end else if (q.ph_idx == `RI_WAKE) begin
        d.wake = i_ahb.hwdata[3:2];
      end else if (q.ph_idx == `RI_TXFL) begin
        d.txfl = i_ahb.hwdata[0];
      end else if (q.ph_idx == `RI_TXFMT) begin
        d.txw = i_ahb.hwdata[0];
      end else if (q.ph_idx == `RI_RXFL) begin
        d.rxfl = i_ahb.hwdata[0];
      end else if (q.ph_idx == `RI_RXFMT) begin
        d.rxw = i_ahb.hwdata[0];
      end else if (q.ph_idx == `RI_BULK) begin
        d.bulk = i_ahb.hwdata[1:0];
      end else if (q.ph_idx == `RI_THR) begin
        d.thr = i_ahb.hwdata[10:0];
      end else if (q.ph_idx == `RI_DRV) begin
        d.drv = i_ahb.hwdata[0];
      end
    end
    // read data is captured in the address phase
    d.rd = 16'h0000;
    if (acc & ~i_ahb.hwrite) begin
      if (aidx == `RI_PULLUP) begin
        d.rd = {8'h00, q.pu};
      end else if (aidx == `RI_PULLDN) begin
        d.rd = {8'h00, q.pd};
      end else if (aidx == `RI_LOOP) begin
        d.rd = {13'h0000, q.lb};
      end else if (aidx == `RI_IR) begin
        d.rd = {13'h0000, q.ir};
      end else if (aidx == `RI_WAKE) begin
        d.rd = {12'h000, q.wake, 2'h0};
      end else if (aidx == `RI_TXLVL) begin
        d.rd = {5'h00, q.txlvl};
      end else if (aidx == `RI_TXFMT) begin
        d.rd = {15'h0000, q.txw};
      end else if (aidx == `RI_RXLVL) begin
        d.rd = {5'h00, q.rxlvl};
      end else if (aidx == `RI_RXFMT) begin
        d.rd = {15'h0000, q.rxw};
      end else if (aidx == `RI_BULK) begin
        d.rd = {14'h0000, q.bulk};
      end else if (aidx == `RI_THR) begin
        d.rd = {5'h00, q.thr};
      end else if (aidx == `RI_DRV) begin
        d.rd = {15'h0000, q.drv};
      end
    end
    // queue levels, clamped to capacity
    d.txlvl = (i_tx_fill > FIFO_BYTES) ? FIFO_BYTES : i_tx_fill;
    d.rxlvl = (i_rx_fill > FIFO_BYTES) ? FIFO_BYTES : i_rx_fill;
    // interrupt word; an event in the build cycle is kept for the next
    d.prev = lvl;
    if (i_int_gen) begin
      d.iword = {q.err | i_err_event, 2'h0, lvl, 2'h0,
                 q.chg | (lvl ^ q.prev)};
      d.err = i_err_event;
      d.chg = lvl ^ q.prev;
    end else begin
      d.err = q.err | i_err_event;
      d.chg = q.chg | (lvl ^ q.prev);
    end
    // wake on falling rx or ring
    d.prx = q.s2[4];
    d.pri = q.s2[0];
    d.resume = (q.wake[1] & q.prx & ~q.s2[4]) |
               (q.wake[0] & q.pri & ~q.s2[0]);
    // infrared pulse: starts at a zero bit, lasts 3 or 4 ticks of 16
    if (i_bit_start & ~i_tx_line) begin
      d.ircnt = q.ir[2] ? `IR_W4 : `IR_W3;
    end else if (i_os_tick & (q.ircnt != 3'h0)) begin
      d.ircnt = q.ircnt - 3'h1;
    end
    if (q.lb[0]) begin
      d.txo = 1'b1;
      d.rxo = i_tx_line;
    end else begin
      d.txo = q.ir[0] ? (d.ircnt != 3'h0) : i_tx_line;
      d.rxo = q.s2[4] ^ q.ir[1];
    end
    // flow control
    d.flow = ((i_flow_mode == `FC_HW) | (i_flow_mode == `FC_SW)) &
             (q.rxlvl > q.thr);
    // tx two-byte assembly
    d.tch_v = 1'b0;
    if (q.txfl | ~q.txw) begin
      d.thalf = 1'b0;
    end
    if (i_txq_valid) begin
      if (~q.txw) begin
        d.tch = {1'b0, i_txq_byte};
        d.tch_v = 1'b1;
      end else if (~q.thalf) begin
        d.tfirst = i_txq_byte;
        d.thalf = 1'b1;
      end else begin
        d.tch = {i_nine_bit & i_txq_byte[0], q.tfirst};
        d.tch_v = 1'b1;
        d.thalf = 1'b0;
      end
    end
    // rx two-byte split: data byte, then error byte
    d.rxb_v = 1'b0;
    d.rpend = 1'b0;
    if (q.rpend & ~q.rxfl) begin
      d.rxb = {4'h0, q.rhold};
      d.rxb_v = 1'b1;
    end else if (i_rx_char_valid) begin
      d.rxb = i_rx_char;
      d.rxb_v = 1'b1;
      d.rhold = i_rx_err;
      d.rpend = q.rxw;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
      q.pu <= `RST_PULLUP;
      q.wake <= `RST_WAKE;
      q.thr <= `RST_THR;
      q.s1 <= 5'h1F;
      q.s2 <= 5'h1F;
      q.prx <= 1'b1;
      q.pri <= 1'b1;
      // idle modem levels, so reset brings no false change bits
      q.prev <= `RST_PREV;
      q.txo <= 1'b1;
      q.rxo <= 1'b1;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    o_hrdata = {16'h0000, q.rd};
    o_hreadyout = 1'b1;
    o_hresp = 1'b0;
    o_tx_pin = q.txo;
    o_tx_oe = ~q.lb[0];
    o_pullup = q.pu;
    o_pulldown = q.pd & ~q.pu;
    o_rx_line = q.rxo;
    o_cts = cts_e;
    o_dsr = dsr_e;
    o_int_status = q.iword;
    o_resume_req = q.resume;
    o_tx_flush = q.txfl;
    o_rx_flush = q.rxfl;
    o_tx_char = q.tch;
    o_tx_char_valid = q.tch_v;
    o_rxq_byte = q.rxb;
    o_rxq_valid = q.rxb_v;
    if (i_high_speed) begin
      o_bulk_max = q.bulk[1] ? `BULK_HS_S : `BULK_HS;
    end else begin
      o_bulk_max = q.bulk[1] ? `BULK_FS_S : `BULK_FS;
    end
    o_low_latency = q.bulk[0];
    o_flow_assert = q.flow;
    o_driver_active = q.drv;
    o_class_mode_ok = ~q.drv;
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_err_seen;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (i_int_gen && i_err_event[0]) |=> o_int_status[16];
  endproperty
  a_err_seen: assert property (p_err_seen)
    else $error("break event lost from interrupt word");

  property p_err_clear;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (i_int_gen && i_err_event == 4'h0) ##1
      (i_int_gen && i_err_event == 4'h0) |=> o_int_status[19:16] == 4'h0;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error flags not cleared after word");

  property p_level_snap;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      i_int_gen |=> o_int_status[13:8] == $past(lvl);
  endproperty
  a_level_snap: assert property (p_level_snap)
    else $error("modem levels not captured");

  property p_pull_excl;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (o_pulldown & o_pullup) == 8'h00;
  endproperty
  a_pull_excl: assert property (p_pull_excl)
    else $error("pull-down active with pull-up");

  property p_loop_tx;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      q.lb[0] |-> !o_tx_oe ##1 ((o_rx_line == $past(i_tx_line))
        && o_tx_pin);
  endproperty
  a_loop_tx: assert property (p_loop_tx)
    else $error("tx loopback path wrong");

  property p_wake_rx;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (q.wake[1] && q.prx && !q.s2[4]) |=> o_resume_req;
  endproperty
  a_wake_rx: assert property (p_wake_rx)
    else $error("rx falling edge gave no resume");

  property p_txflush;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (q.ph_wr && q.ph_idx == `RI_TXFL && i_ahb.hwdata[0])
        |=> o_tx_flush ##1 !o_tx_flush;
  endproperty
  a_txflush: assert property (p_txflush)
    else $error("tx flush not a single pulse");

  property p_flow;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (i_flow_mode == `FC_NONE) |=> !o_flow_assert;
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow asserted with mode none");

  property p_ir_width;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (i_bit_start && !i_tx_line && !q.ir[2]) |=> q.ircnt == 3'h3;
  endproperty
  a_ir_width: assert property (p_ir_width)
    else $error("infrared pulse width not 3 ticks");

  property p_rx_err_byte;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (q.rpend && !q.rxfl) |=> o_rxq_valid && o_rxq_byte[7:4] == 4'h0;
  endproperty
  a_rx_err_byte: assert property (p_rx_err_byte)
    else $error("rx error byte missing");

  property p_class_mode;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      o_driver_active |-> !o_class_mode_ok;
  endproperty
  a_class_mode: assert property (p_class_mode)
    else $error("class mode allowed with driver active");
endmodule : usb_uart_control_status
